// File: shared/gauge_regs_defs.vh
/*
 * constants for the gauge status and switch-override register bank:
 * command codes, field positions, masks and reset values.
 * assumes it is included by bare name from design files only.
 */
`ifndef GAUGE_REGS_DEFS_VH
`define GAUGE_REGS_DEFS_VH

// command codes of the extended set served here
`define CMD_FRONTEND_SNAPSHOT 8'h45
`define CMD_SWITCH_OVERRIDE 8'h46
`define CMD_SAFETY_PENDING 8'h50
`define CMD_SAFETY_FAULTS 8'h51
`define CMD_PERMANENT_PENDING 8'h52
`define CMD_PERMANENT_FAIL_CAUSE 8'h53
`define CMD_OPERATION_FLAGS 8'h54

// snapshot block length byte, front-end bytes returned
`define SNAPSHOT_LEN 8'h09

// switch override word fields
`define SW_DISCHARGE 1
`define SW_CHARGE 2
`define SW_PRECHARGE 3
`define SW_OPEN_DRAIN 4
`define SW_OVERRIDE 7
`define SWITCH_WRITE_MASK 16'h009E
`define SWITCH_RESET 16'h0000

// safety words: bit 3 reserved, all others fault flags
`define SAFETY_VALID_MASK 16'hFFF7
// permanent failure words: every bit is a cause
`define PF_VALID_MASK 16'hFFFF

// operation flags word fields
`define OP_INSERTED 15
`define OP_FULL_ACCESS 14
`define OP_SEALED 13
`define OP_LOAD_MODE 10
`define OP_WAKE 7
`define OP_DISCHARGING 6
`define OP_DISCHARGE_FAULT 5
`define OP_BLOCK_CURRENT 4
`define OP_BLOCK_TEMP 3
`define OP_BLOCK_VOLT 2
`define OP_VOLT_FIT 1
`define OP_UPDATE_EN 0

// smbus slave address of the gauge
`define SLAVE_ADDR 7'h0B

`endif

// File: logic/snapshot_mem.v
/*
 * small byte memory holding the front-end register snapshot.
 * assumes one clock, write port from the front-end poller,
 * read data registered one cycle after the address.
 */
`timescale 1ns/1ns
module snapshot_mem #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
)(
    input wire i_clk,
    input wire i_ce,
    input wire i_wr,
    input wire [AW-1:0] i_waddr,
    input wire [WIDTH-1:0] i_wdata,
    input wire [AW-1:0] i_raddr,
    output reg [WIDTH-1:0] o_rdata
);
    // storage, no reset: contents are refreshed by the poller
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // write port
    always @(posedge i_clk)
    begin
        if (i_ce && i_wr)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // registered read port
    always @(posedge i_clk)
    begin
        if (i_ce)
        begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// File: logic/gauge_regs.v
/*
 * gauge extended register bank on an smbus slave: front-end snapshot
 * block read, switch override word, safety and permanent failure
 * words, operation flags and the permanent failure records.
 * assumes scl, sda and the presence pin come from outside the clock
 * domain; all other inputs come from gauge logic on i_clk.
 */
`timescale 1ns/1ns
`include "gauge_regs_defs.vh"

// Behaviour
// - extended commands refused while sealed
// - 0x45 block: length then nine snapshot bytes
// - 0x46 read/write switch and override bits
// - switch bit one on, zero off
// - override set holds commanded switch states
// - override clear lets gauge drive switches
// - front-end off demand always wins
// - 0x50 pending safety, fault layout
// - 0x51 current safety fault flags
// - safety high byte fault order
// - safety low byte fault order
// - 0x52 pending permanent failure bits
// - 0x53 permanent failure cause word
// - history record accumulates every cause
// - first nonzero cause stored once
// - operation high byte flag positions
// - operation low byte flag positions
// - load mode selects constant power model
// - discharging bit mirrors battery status
// - inserted flag set while pin low
module gauge_regs #(
    parameter ADDR = `SLAVE_ADDR
)(
    input wire i_clk,
    input wire i_resetn,
    input wire i_ce,
    input wire i_scl,
    input wire i_sda,
    output wire o_sda_out,
    output wire o_sda_oe,
    input wire i_sealed,
    input wire i_full_access,
    input wire i_load_mode,
    input wire i_system_inserted_n,
    input wire i_wake,
    input wire i_discharging,
    input wire i_discharge_fault,
    input wire i_block_current,
    input wire i_block_temp,
    input wire i_block_volt,
    input wire i_voltage_fit,
    input wire i_update_en,
    input wire [15:0] i_safety_pending,
    input wire [15:0] i_safety_faults,
    input wire [15:0] i_pf_pending,
    input wire [15:0] i_pf_cause,
    input wire [3:0] i_gauge_switch,
    input wire [3:0] i_frontend_off,
    input wire i_snap_wr,
    input wire [3:0] i_snap_addr,
    input wire [7:0] i_snap_data,
    output reg o_discharge_switch,
    output reg o_charge_switch,
    output reg o_precharge_switch,
    output reg o_open_drain_out,
    output reg o_constant_power,
    output reg [15:0] o_failure_history_record,
    output reg o_history_wr,
    output reg [15:0] o_first_failure_record,
    output reg o_first_wr
);
    // bus states
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_CMD = 3'd2;
    localparam ST_WDATA = 3'd3;
    localparam ST_READ = 3'd4;
    localparam ST_WAIT = 3'd5;

    // synchronisers: stage one is read only by stage two
    reg scl_m_q, scl_s_q, scl_p_q;
    reg sda_m_q, sda_s_q, sda_p_q;
    reg ins_m_q, ins_s_q;

    // bus engine state
    reg [2:0] st_q;
    reg [2:0] nxt_q; // state taken after the ack slot
    reg [3:0] bit_q; // bit counter, 8/9 ack slot, 10 reload
    reg [7:0] sh_q; // receive shift register
    reg [7:0] tx_q; // transmit shift register
    reg sda_low_q; // we pull sda low
    reg [7:0] cmd_q; // last accepted command
    reg cmd_ok_q; // command valid for a repeated-start read
    reg [1:0] wcnt_q; // write data byte count
    reg [7:0] lo_q; // low byte of a word write
    reg [4:0] idx_q; // byte index of a read
    reg [15:0] ctrl_q; // switch override word
    reg hold_q; // commanded states are being held
    reg first_taken_q; // first failure already captured

    wire [7:0] mem_rdata;
    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;
    // sda moves while scl high only for start and stop
    wire start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    wire stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    wire rx_st = (st_q == ST_ADDR) || (st_q == ST_CMD) || (st_q == ST_WDATA);

    reg [15:0] op_word; // assembled operation flags
    reg [15:0] rd_word; // word answered for the current command

    // commands this bank answers
    function cmd_known;
        input [7:0] c;
        begin
            cmd_known = (c == `CMD_FRONTEND_SNAPSHOT) || (c == `CMD_SWITCH_OVERRIDE)
                || (c == `CMD_SAFETY_PENDING) || (c == `CMD_SAFETY_FAULTS)
                || (c == `CMD_PERMANENT_PENDING) || (c == `CMD_PERMANENT_FAIL_CAUSE)
                || (c == `CMD_OPERATION_FLAGS);
        end
    endfunction

    // byte k of a read answer; words go low byte first
    function [7:0] byte_sel;
        input [7:0] c;
        input [4:0] k;
        input [15:0] w;
        input [7:0] m;
        begin
            if (c == `CMD_FRONTEND_SNAPSHOT)
            begin
                // length byte then location zero first
                if (k == 5'd0)
                    byte_sel = `SNAPSHOT_LEN;
                else if (k <= 5'd9)
                    byte_sel = m;
                else
                    byte_sel = 8'h00;
            end
            else if (k == 5'd0)
                byte_sel = w[7:0];
            else if (k == 5'd1)
                byte_sel = w[15:8];
            else
                byte_sel = 8'h00;
        end
    endfunction

    // front-end snapshot store; byte k+1 of the block is location k
    snapshot_mem #(
        .WIDTH(8),
        .DEPTH(16),
        .AW(4)
    ) u_snap (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_wr(i_snap_wr),
        .i_waddr(i_snap_addr),
        .i_wdata(i_snap_data),
        .i_raddr(idx_q[3:0]),
        .o_rdata(mem_rdata)
    );

    // operation flags word
    always @*
    begin
        op_word = 16'h0000;
        op_word[`OP_INSERTED] = ~ins_s_q;
        op_word[`OP_FULL_ACCESS] = i_full_access;
        op_word[`OP_SEALED] = i_sealed;
        op_word[`OP_LOAD_MODE] = i_load_mode;
        op_word[`OP_WAKE] = i_wake;
        op_word[`OP_DISCHARGING] = i_discharging;
        op_word[`OP_DISCHARGE_FAULT] = i_discharge_fault;
        op_word[`OP_BLOCK_CURRENT] = i_block_current;
        op_word[`OP_BLOCK_TEMP] = i_block_temp;
        op_word[`OP_BLOCK_VOLT] = i_block_volt;
        op_word[`OP_VOLT_FIT] = i_voltage_fit;
        op_word[`OP_UPDATE_EN] = i_update_en;
    end

    // read word mux
    always @*
    begin
        case (cmd_q)
            // override word reads back, reserved bits zero
            `CMD_SWITCH_OVERRIDE: rd_word = ctrl_q & `SWITCH_WRITE_MASK;
            // pending bits share the fault layout
            `CMD_SAFETY_PENDING: rd_word = i_safety_pending & `SAFETY_VALID_MASK;
            `CMD_SAFETY_FAULTS: rd_word = i_safety_faults & `SAFETY_VALID_MASK;
            `CMD_PERMANENT_PENDING: rd_word = i_pf_pending & `PF_VALID_MASK;
            `CMD_PERMANENT_FAIL_CAUSE: rd_word = i_pf_cause & `PF_VALID_MASK;
            `CMD_OPERATION_FLAGS: rd_word = op_word;
            default: rd_word = 16'h0000;
        endcase
    end

    // input synchronisers, pins only
    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            ins_m_q <= 1'b1;
            ins_s_q <= 1'b1;
        end
        else if (i_ce)
        begin
            scl_m_q <= i_scl;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= i_sda;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            ins_m_q <= i_system_inserted_n;
            ins_s_q <= ins_m_q;
        end
    end

    // smbus slave engine
    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_q <= ST_IDLE;
            nxt_q <= ST_IDLE;
            bit_q <= 4'd0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            sda_low_q <= 1'b0;
            cmd_q <= 8'h00;
            cmd_ok_q <= 1'b0;
            wcnt_q <= 2'd0;
            lo_q <= 8'h00;
            idx_q <= 5'd0;
            ctrl_q <= `SWITCH_RESET;
            hold_q <= 1'b0;
        end
        else if (i_ce)
        begin
            if (stop_c)
            begin
                // stop ends everything, command forgotten
                st_q <= ST_IDLE;
                sda_low_q <= 1'b0;
                cmd_ok_q <= 1'b0;
                bit_q <= 4'd0;
            end
            else if (start_c)
            begin
                // start or repeated start: listen for address
                st_q <= ST_ADDR;
                sda_low_q <= 1'b0;
                bit_q <= 4'd0;
            end
            else if (rx_st)
            begin
                if (scl_rise && (bit_q < 4'd8))
                begin
                    sh_q <= {sh_q[6:0], sda_s_q};
                    bit_q <= bit_q + 4'd1;
                end
                else if (scl_fall && (bit_q == 4'd8))
                begin
                    // byte complete: decide ack and act on it
                    bit_q <= 4'd9;
                    sda_low_q <= 1'b0;
                    nxt_q <= ST_WAIT;
                    case (st_q)
                        ST_ADDR:
                        begin
                            if ((sh_q[7:1] == ADDR) && !sh_q[0])
                            begin
                                sda_low_q <= 1'b1;
                                nxt_q <= ST_CMD;
                            end
                            else if ((sh_q[7:1] == ADDR) && cmd_ok_q)
                            begin
                                sda_low_q <= 1'b1;
                                nxt_q <= ST_READ;
                                idx_q <= 5'd0;
                                tx_q <= byte_sel(cmd_q, 5'd0, rd_word, mem_rdata);
                            end
                        end
                        ST_CMD:
                        begin
                            // sealed gauge answers none of these
                            if (cmd_known(sh_q) && !i_sealed)
                            begin
                                sda_low_q <= 1'b1;
                                nxt_q <= ST_WDATA;
                                cmd_q <= sh_q;
                                cmd_ok_q <= 1'b1;
                                wcnt_q <= 2'd0;
                            end
                            else
                            begin
                                cmd_ok_q <= 1'b0;
                            end
                        end
                        ST_WDATA:
                        begin
                            // only the override word is writable, two bytes
                            if ((cmd_q == `CMD_SWITCH_OVERRIDE) && (wcnt_q < 2'd2))
                            begin
                                sda_low_q <= 1'b1;
                                nxt_q <= ST_WDATA;
                                wcnt_q <= wcnt_q + 2'd1;
                                if (wcnt_q == 2'd0)
                                begin
                                    lo_q <= sh_q;
                                end
                                else
                                begin
                                    ctrl_q <= {sh_q, lo_q} & `SWITCH_WRITE_MASK;
                                    hold_q <= lo_q[`SW_OVERRIDE];
                                end
                            end
                        end
                        default:
                        begin
                            nxt_q <= ST_WAIT;
                        end
                    endcase
                end
                else if (scl_fall && (bit_q == 4'd9))
                begin
                    // end of ack slot
                    st_q <= nxt_q;
                    if (nxt_q == ST_READ)
                    begin
                        sda_low_q <= ~tx_q[7];
                        bit_q <= 4'd1;
                    end
                    else
                    begin
                        sda_low_q <= 1'b0;
                        bit_q <= 4'd0;
                    end
                end
            end
            else if (st_q == ST_READ)
            begin
                if (scl_fall && (bit_q < 4'd8))
                begin
                    // shift out next bit, msb first
                    sda_low_q <= ~tx_q[6];
                    tx_q <= {tx_q[6:0], 1'b0};
                    bit_q <= bit_q + 4'd1;
                end
                else if (scl_fall && (bit_q == 4'd8))
                begin
                    // release for the master's ack
                    sda_low_q <= 1'b0;
                    bit_q <= 4'd9;
                end
                else if (scl_rise && (bit_q == 4'd9))
                begin
                    if (sda_s_q)
                    begin
                        // master nack: transfer over
                        st_q <= ST_WAIT;
                    end
                    else
                    begin
                        // memory data at idx is already registered
                        idx_q <= idx_q + 5'd1;
                        tx_q <= byte_sel(cmd_q, idx_q + 5'd1, rd_word, mem_rdata);
                        bit_q <= 4'd10;
                    end
                end
                else if (scl_fall && (bit_q == 4'd10))
                begin
                    sda_low_q <= ~tx_q[7];
                    bit_q <= 4'd1;
                end
            end
        end
    end

    // switch drivers
    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_discharge_switch <= 1'b0;
            o_charge_switch <= 1'b0;
            o_precharge_switch <= 1'b0;
            o_open_drain_out <= 1'b0;
            o_constant_power <= 1'b0;
        end
        else if (i_ce)
        begin
            // held bits set on, cleared off
            // without the hold the gauge decides
            // front-end off demand masks both sources
            o_discharge_switch <= (hold_q ? ctrl_q[`SW_DISCHARGE] : i_gauge_switch[0])
                & ~i_frontend_off[0];
            o_charge_switch <= (hold_q ? ctrl_q[`SW_CHARGE] : i_gauge_switch[1])
                & ~i_frontend_off[1];
            o_precharge_switch <= (hold_q ? ctrl_q[`SW_PRECHARGE] : i_gauge_switch[2])
                & ~i_frontend_off[2];
            o_open_drain_out <= (hold_q ? ctrl_q[`SW_OPEN_DRAIN] : i_gauge_switch[3])
                & ~i_frontend_off[3];
            // one picks the constant power model
            o_constant_power <= i_load_mode;
        end
    end

    // permanent failure records, written out as pulses for storage
    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_failure_history_record <= 16'h0000;
            o_history_wr <= 1'b0;
            o_first_failure_record <= 16'h0000;
            o_first_wr <= 1'b0;
            first_taken_q <= 1'b0;
        end
        else if (i_ce)
        begin
            o_history_wr <= 1'b0;
            o_first_wr <= 1'b0;
            // merge any cause not yet in history
            if ((i_pf_cause & ~o_failure_history_record) != 16'h0000)
            begin
                o_failure_history_record <= o_failure_history_record | i_pf_cause;
                o_history_wr <= 1'b1;
            end
            // first nonzero cause word, once only
            if (!first_taken_q && (i_pf_cause != 16'h0000))
            begin
                o_first_failure_record <= i_pf_cause;
                o_first_wr <= 1'b1;
                first_taken_q <= 1'b1;
            end
        end
    end

    // open-drain data pin: only ever pulled low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_low_q;
endmodule

// File: tb/gauge_regs_assertions.sv
/* checker for the switch outputs and failure records.
   assumes binding to gauge_regs with i_ce held high. */
`timescale 1ns/1ns
module gauge_regs_assertions (
    input wire i_clk,
    input wire i_resetn,
    input wire i_load_mode,
    input wire [15:0] i_pf_cause,
    input wire [3:0] i_frontend_off,
    input wire o_discharge_switch,
    input wire o_charge_switch,
    input wire o_precharge_switch,
    input wire o_open_drain_out,
    input wire o_constant_power,
    input wire [15:0] o_failure_history_record,
    input wire o_history_wr,
    input wire [15:0] o_first_failure_record,
    input wire o_first_wr
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // switches in front-end demand order
    wire [3:0] sw = {o_open_drain_out, o_precharge_switch, o_charge_switch, o_discharge_switch};
    // a cause missing from the history
    sequence s_new_cause;
        (i_pf_cause & ~o_failure_history_record) != 16'h0000;
    endsequence
    // nonzero cause, nothing captured yet
    sequence s_first_due;
        o_first_failure_record == 16'h0000 && i_pf_cause != 16'h0000;
    endsequence
    AST_FRONTEND_OFF: assert property (1'h1 |=> (sw & $past(i_frontend_off)) == 4'h0)
        else $error("switch on against front-end off");
    AST_LOAD_MODE: assert property (1'h1 |=> o_constant_power == $past(i_load_mode))
        else $error("load model not following");
    AST_HIST_GROW: assert property (s_new_cause |=> o_history_wr &&
        o_failure_history_record == ($past(o_failure_history_record) | $past(i_pf_cause)))
        else $error("history not merged");
    AST_HIST_HOLD: assert property (!o_history_wr |-> $stable(o_failure_history_record))
        else $error("history changed silently");
    AST_HIST_PULSE: assert property (o_history_wr |->
        o_failure_history_record != $past(o_failure_history_record))
        else $error("history pulse without change");
    AST_FIRST_TAKE: assert property (s_first_due |=> o_first_wr &&
        o_first_failure_record == $past(i_pf_cause))
        else $error("first cause not captured");
    AST_FIRST_KEEP: assert property (o_first_failure_record != 16'h0000 |=>
        $stable(o_first_failure_record) && !o_first_wr)
        else $error("first record overwritten");
    AST_FIRST_IN_HIST: assert property (
        (o_first_failure_record & ~o_failure_history_record) == 16'h0000)
        else $error("first cause missing from history");
endmodule
bind gauge_regs gauge_regs_assertions gauge_regs_assertions_inst (
    .i_clk, .i_resetn, .i_load_mode, .i_pf_cause, .i_frontend_off, .o_discharge_switch,
    .o_charge_switch, .o_precharge_switch, .o_open_drain_out, .o_constant_power,
    .o_failure_history_record, .o_history_wr, .o_first_failure_record, .o_first_wr
);

// File: tb/smbus_host.sv
/* smbus host model on the gauge clock and data pins.
   assumes a pulled-up data line and i_clk at 125 MHz. */
`timescale 1ns/1ns
module smbus_host (
    input wire i_clk,
    input wire i_sda_oe,
    output logic o_scl = 1'h1,
    output wire o_sda
);
    logic drv_low = 1'h0; // host pulls data low
    // open drain with pull-up: released reads high
    assign o_sda = !(drv_low || i_sda_oe);
    // quarter of the 160 ns bus period
    task automatic qtr;
        repeat (5) @(negedge i_clk);
    endtask
    // data set mid-low, sampled mid-high
    task automatic slot(input logic b, output logic s);
        drv_low = !b;
        qtr;
        o_scl = 1'h1;
        qtr;
        s = o_sda;
        qtr;
        o_scl = 1'h0;
        qtr;
    endtask
    // data falls while clock high
    task automatic start;
        drv_low = 1'h0;
        qtr;
        o_scl = 1'h1;
        qtr;
        drv_low = 1'h1;
        qtr;
        o_scl = 1'h0;
        qtr;
    endtask
    // data rises while clock high, clock then stands
    task automatic stop;
        drv_low = 1'h1;
        qtr;
        o_scl = 1'h1;
        qtr;
        drv_low = 1'h0;
        qtr;
    endtask
    // msb first, then the ack slot
    task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] r,
        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            slot(d[i], s);
            r[i] = s;
        end
        slot(m, s);
        ack = !s;
    endtask
endmodule

// File: tb/tb_top.sv
/* self-checking bench for the gauge register bank.
   assumes the smbus host model and the bound checker. */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
    logic i_clk = 1'h0;
    logic i_resetn = 1'h0;
    logic [15:0] op = '0; // operation flag inputs, word layout
    logic [15:0] i_safety_pending = '0;
    logic [15:0] i_safety_faults = '0;
    logic [15:0] i_pf_pending = '0;
    logic [15:0] i_pf_cause = '0;
    logic [3:0] i_gauge_switch = '0;
    logic [3:0] i_frontend_off = '0;
    logic i_snap_wr = 1'h0;
    logic [3:0] i_snap_addr = '0;
    logic [7:0] i_snap_data = '0;
    logic [7:0] rbuf [0:10]; // bytes of the last read
    wire scl, sda, o_sda_oe, o_constant_power, o_discharge_switch, o_charge_switch;
    wire o_precharge_switch, o_open_drain_out;
    wire [15:0] hist, first;
    wire [3:0] sw = {o_open_drain_out, o_precharge_switch, o_charge_switch, o_discharge_switch};
    wire [15:0] rw = {rbuf[1], rbuf[0]}; // words arrive low byte first
    int failures = 0;
    int checks_done = 0, cycles = 0;
    gauge_regs gauge_regs_inst (.i_clk, .i_resetn, .i_ce(1'h1), .i_scl(scl), .i_sda(sda),
        .o_sda_out(), .o_sda_oe, .i_sealed(op[13]), .i_full_access(op[14]),
        .i_load_mode(op[10]), .i_system_inserted_n(!op[15]), .i_wake(op[7]),
        .i_discharging(op[6]), .i_discharge_fault(op[5]), .i_block_current(op[4]),
        .i_block_temp(op[3]), .i_block_volt(op[2]), .i_voltage_fit(op[1]),
        .i_update_en(op[0]), .i_safety_pending, .i_safety_faults, .i_pf_pending,
        .i_pf_cause, .i_gauge_switch, .i_frontend_off, .i_snap_wr, .i_snap_addr,
        .i_snap_data, .o_discharge_switch, .o_charge_switch, .o_precharge_switch,
        .o_open_drain_out, .o_constant_power, .o_failure_history_record(hist),
        .o_history_wr(), .o_first_failure_record(first), .o_first_wr());
    smbus_host host (.i_clk, .i_sda_oe(o_sda_oe), .o_scl(scl), .o_sda(sda));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // word write, all four bytes acked checked against exp
    task automatic wr(input logic [7:0] cmd, input logic [15:0] w, input logic exp);
        logic [7:0] r;
        logic [3:0] a;
        host.start;
        host.xfer(8'h16, 1'h1, r, a[0]);
        host.xfer(cmd, 1'h1, r, a[1]);
        host.xfer(w[7:0], 1'h1, r, a[2]);
        host.xfer(w[15:8], 1'h1, r, a[3]);
        host.stop;
        `CHK("write ack", exp, &a)
    endtask
    // read of n bytes, host refuses the last
    task automatic rd(input logic [7:0] cmd, input int n, input logic exp);
        logic [7:0] v;
        logic [2:0] a;
        logic x;
        host.start;
        host.xfer(8'h16, 1'h1, v, a[0]);
        host.xfer(cmd, 1'h1, v, a[1]);
        host.start;
        host.xfer(8'h17, 1'h1, v, a[2]);
        for (int i = 0; i < n; i++)
        begin
            host.xfer(8'hFF, i == n - 1, v, x);
            rbuf[i] = v;
        end
        host.stop;
        `CHK("read ack", exp, &a)
    endtask
    task automatic t_switch;
        @(negedge i_clk);
        i_gauge_switch = 4'hA;
        wr(8'h46, 16'hFFFF, 1'h1);
        rd(8'h46, 2, 1'h1);
        `CHK("switch word", 16'h009E, rw)
        `CHK("all on", 4'hF, sw)
        i_frontend_off = 4'h2;
        repeat (2) @(negedge i_clk);
        `CHK("charge forced off", 4'hD, sw)
        i_frontend_off = 4'h0;
        wr(8'h46, 16'h008A, 1'h1);
        `CHK("override held", 4'h5, sw)
        wr(8'h46, 16'h0000, 1'h1);
        `CHK("gauge drives", 4'hA, sw)
        $display("test switch done");
    endtask
    task automatic t_sealed;
        op[13] = 1'h1;
        rd(8'h51, 2, 1'h0);
        wr(8'h46, 16'h0086, 1'h0);
        `CHK("switches kept", 4'hA, sw)
        op[13] = 1'h0;
        rd(8'h47, 2, 1'h0);
        $display("test sealed done");
    endtask
    task automatic t_snapshot;
        for (int i = 0; i < 10; i++)
        begin
            i_snap_wr = 1'h1;
            i_snap_addr = i[3:0];
            i_snap_data = 8'hA0 + i[7:0];
            @(negedge i_clk);
        end
        i_snap_wr = 1'h0;
        rd(8'h45, 11, 1'h1);
        `CHK("length", 8'h09, rbuf[0])
        for (int i = 1; i < 10; i++) `CHK("snapshot", 8'h9F + i[7:0], rbuf[i])
        `CHK("past end", 8'h00, rbuf[10])
        $display("test snapshot done");
    endtask
    task automatic t_records;
        i_pf_cause = 16'h0010;
        repeat (3) @(negedge i_clk);
        i_pf_cause = 16'h0001;
        repeat (3) @(negedge i_clk);
        i_pf_cause = 16'h0100;
        repeat (3) @(negedge i_clk);
        `CHK("first record", 16'h0010, first)
        `CHK("history", 16'h0111, hist)
        $display("test records done");
    endtask
    task automatic t_status;
        i_safety_pending = 16'h5A5A;
        i_safety_faults = 16'hFFFF;
        i_pf_pending = 16'hC3A5;
        op = 16'hDFFF;
        rd(8'h50, 2, 1'h1);
        `CHK("safety pending", 16'h5A52, rw)
        rd(8'h51, 2, 1'h1);
        `CHK("safety faults", 16'hFFF7, rw)
        rd(8'h52, 2, 1'h1);
        `CHK("pf pending", 16'hC3A5, rw)
        rd(8'h53, 2, 1'h1);
        `CHK("pf cause", 16'h0100, rw)
        rd(8'h54, 2, 1'h1);
        `CHK("op flags", 16'hC4FF, rw)
        `CHK("constant power", 1'h1, o_constant_power)
        op = 16'h0055;
        rd(8'h54, 2, 1'h1);
        `CHK("op flags", 16'h0055, rw)
        `CHK("constant current", 1'h0, o_constant_power)
        $display("test status done");
    endtask
    // free-running clock
    initial
    begin
        forever #4 i_clk = ~i_clk;
    end
    // cuts a hung bus short
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            failures++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (16) @(negedge i_clk);
        i_resetn = 1'h1;
        repeat (4) @(negedge i_clk);
        t_switch;
        t_sealed;
        t_snapshot;
        t_records;
        t_status;
        tally_and_finish;
    end
endmodule
